/* File: verilog/dpsem_host.sv */
`timescale 1ns/1ns
// Functional notes
// [R01] master drives conflict indication; slaves use it as write inhibit
// [R02] configure exactly one device as master in a width-expanded array
// [R03] master decides conflicts from chip select and address only
// [R04] hold address and select valid before starting the write strobe
// [R05] eight token latches apart from the main memory, reachable by both
// [R06] tokens active low: write zero requests, same port writes one to free
// [R07] dedicated low token select, address, select, read/write as usual sram
// [R08] only the three lowest address lines choose a token latch
// [R09] port is in standby while neither chip select nor token select active
// [R10] token flags gate no memory region; meaning is left to software
// [R11] token accesses insert no wait states; ports do not slow each other
// [R12] simultaneous token accesses from both ports resolve unambiguously
// [R13] requester writes, then reads back; on failure polls or withdraws
// [R14] token writes use data bit zero; reads show flag on all sixteen bits
// [R15] a losing zero stays pending and takes the token when holder frees it
// [R16] read value latched while token select and output enable both active
// [R17] earlier request wins; exact tie grants exactly one port
// [R18] at start-up write one to every token latch
module dpsem_host
  import dpsem_pkg::*;
(
  input  wire logic                   mclk,                 // 100 MHz clock
  input  wire logic                   reset_n,              // async reset
  input  wire logic                   cmd_valid,            // start command
  input  wire logic                   cmd_acquire,          // 1 request, 0 free
  input  wire logic [DPSEM_SEL_W-1:0] cmd_token,            // token number
  output logic                        cmd_ready,            // idle, may start
  output logic                        done,                 // result pulse
  output logic                        granted,              // token held
  output logic                        init_busy,            // start-up clear
  output logic                        token_space_select_n, // token select
  output logic                        chip_select_n,        // memory select
  output logic                        rw_n,                 // 1 read 0 write
  output logic                        output_enable_n,      // device drives bus
  output logic [DPSEM_AW-1:0]         addr,                 // address pins
  output logic [DPSEM_DW-1:0]         data_out,             // data to pins
  output logic                        data_oe,              // we drive data
  input  wire logic [DPSEM_DW-1:0]    data_in               // data from pins
);
  dpsem_state_t state_r, state_nxt;
  logic [3:0]             cnt_r;
  logic                   is_write_r;       // current phase is a write
  logic                   acq_r;            // command is an acquire
  logic [DPSEM_SEL_W-1:0] tok_r;
  logic [DPSEM_SEL_W:0]   init_idx_r;       // start-up sweep index
  logic                   init_r;
  logic [DPSEM_DW-1:0]    d_s1_r, d_s2_r;   // pin synchroniser

  wire cnt_end     = (cnt_r == DPSEM_CNT_ONE);
  wire setup_end   = (state_r == DPSEM_SETUP) && cnt_end;
  wire strobe_end  = (state_r == DPSEM_STROBE) && cnt_end;
  // taken only while ready is shown, so the first idle cycle after the start-up sweep is skipped
  wire start_cmd   = (state_r == DPSEM_IDLE) && cmd_ready && cmd_valid;
  wire start_init  = (state_r == DPSEM_IDLE) && init_r;
  // acquire reads back after its write; release has no read phase
  wire need_read   = is_write_r && acq_r && !init_r; // [R13]
  // flag is replicated on all bits, so bit zero suffices
  wire flag_low    = !d_s2_r[0]; // [R14]
  wire init_last   = (init_idx_r == (DPSEM_SEL_W+1)'(DPSEM_NUM_TOK - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DPSEM_IDLE:   if (start_cmd || start_init) state_nxt = DPSEM_SETUP;
      DPSEM_SETUP:  if (cnt_end) state_nxt = DPSEM_STROBE; // [R04]
      DPSEM_STROBE: if (cnt_end) state_nxt = DPSEM_HOLD;
      DPSEM_HOLD:   state_nxt = need_read ? DPSEM_SETUP : DPSEM_DONE;
      DPSEM_DONE:   state_nxt = DPSEM_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= DPSEM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 4'h0;
    end else if (state_r == DPSEM_IDLE || strobe_end) begin
      cnt_r <= 4'(DPSEM_SETUP_CYC);
    end else if (setup_end) begin
      cnt_r <= 4'(DPSEM_STROBE_CYC);
    end else if (state_r == DPSEM_HOLD) begin
      cnt_r <= 4'(DPSEM_SETUP_CYC);
    end else if (!cnt_end) begin
      cnt_r <= cnt_r - DPSEM_CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      is_write_r <= 1'b1;
      acq_r      <= 1'b0;
      tok_r      <= 3'h0;
    end else if (start_cmd) begin
      is_write_r <= 1'b1;
      acq_r      <= cmd_acquire;
      tok_r      <= cmd_token;
    end else if (start_init) begin
      is_write_r <= 1'b1;
      acq_r      <= 1'b0;
      tok_r      <= init_idx_r[DPSEM_SEL_W-1:0];
    end else if (state_r == DPSEM_HOLD) begin
      is_write_r <= !need_read;
    end
  end

  // sweep writes one to all eight latches before taking commands
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      init_r     <= 1'b1;
      init_idx_r <= 4'h0;
    end else if (init_r && state_r == DPSEM_DONE) begin
      init_idx_r <= init_idx_r + 4'h1;
      if (init_last) init_r <= 1'b0; // [R18]
    end
  end

  always_ff @(posedge mclk) begin
    d_s1_r <= data_in;
    d_s2_r <= d_s1_r;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      granted <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= (state_r == DPSEM_HOLD) && !need_read && !init_r;
      // sample last strobe cycle of the read, before select goes away
      if (strobe_end && !is_write_r) granted <= flag_low; // [R16]
      else if (strobe_end && is_write_r && !acq_r) granted <= 1'b0; // [R06]
    end
  end

  wire active    = (state_r == DPSEM_SETUP) || (state_r == DPSEM_STROBE);
  wire strobing  = (state_r == DPSEM_STROBE);
  // write zero to request, one to free; only bit zero carries it
  wire [DPSEM_DW-1:0] wr_val = acq_r ? DPSEM_DATA_ZERO
                                     : DPSEM_DATA_ONE; // [R06] [R14]
  wire next_access = (state_nxt == DPSEM_SETUP) ||
                     (state_nxt == DPSEM_STROBE);
  wire next_strobe = (state_nxt == DPSEM_STROBE);
  wire sel_n_nxt   = !next_access; // [R07] [R09]
  // setup before strobe lets a single master's conflict output settle
  wire rw_n_nxt    = !(is_write_r && next_strobe
                       && active); // [R01] [R02] [R04]
  wire oe_n_nxt    = !(!is_write_r && next_strobe && active);
  wire [DPSEM_AW-1:0] addr_nxt =
    {{(DPSEM_AW-DPSEM_SEL_W){1'b0}}, tok_r}; // [R08]
  wire data_oe_nxt = is_write_r && active && (strobing || next_strobe);
  wire ready_nxt   = (state_nxt == DPSEM_IDLE) && !init_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      token_space_select_n <= 1'b1;
    end else begin
      token_space_select_n <= sel_n_nxt; // [R07] [R09]
    end
  end

  // memory select held off so the port sees a pure token access
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_n <= 1'b1;
    end else begin
      chip_select_n <= 1'b1; // [R07]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rw_n <= 1'b1;
    end else begin
      rw_n <= rw_n_nxt; // [R04]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      output_enable_n <= 1'b1;
    end else begin
      output_enable_n <= oe_n_nxt; // [R16]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr <= 16'h0000;
    end else begin
      addr <= addr_nxt; // [R08]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= 16'h0000;
    end else begin
      data_out <= wr_val; // [R14]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= data_oe_nxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= ready_nxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      init_busy <= 1'b1;
    end else begin
      init_busy <= init_r; // [R18]
    end
  end
endmodule // dpsem_host

/* File: verilog/dpsem_pkg.sv */
package dpsem_pkg;
  localparam int DPSEM_AW        = 16;
  localparam int DPSEM_DW        = 16;
  localparam int DPSEM_SEL_W     = 3;
  localparam int DPSEM_NUM_TOK   = 8;
  localparam int DPSEM_CLK_NS    = 10;
  localparam int DPSEM_SETUP_NS  = 30;  // address/select settle before strobe
  localparam int DPSEM_STROBE_NS = 30;  // write strobe / read output width
  localparam int DPSEM_SETUP_CYC =
    (DPSEM_SETUP_NS + DPSEM_CLK_NS - 1) / DPSEM_CLK_NS;
  localparam int DPSEM_STROBE_CYC =
    (DPSEM_STROBE_NS + DPSEM_CLK_NS - 1) / DPSEM_CLK_NS;
  localparam logic [3:0] DPSEM_CNT_ONE = 4'h1;
  localparam logic [DPSEM_DW-1:0] DPSEM_DATA_ZERO = 16'h0000;
  localparam logic [DPSEM_DW-1:0] DPSEM_DATA_ONE  = 16'h0001;
  typedef enum logic [2:0] {
    DPSEM_IDLE, DPSEM_SETUP, DPSEM_STROBE, DPSEM_HOLD, DPSEM_DONE
  } dpsem_state_t;
endpackage : dpsem_pkg

/* File: sim/dpsem_dev_model.sv */
`timescale 1ns/1ns
module dpsem_dev_model
  import dpsem_pkg::*;
(
  input  wire logic                l_sel_n, // token select
  input  wire logic                l_ce_n,  // memory select
  input  wire logic                l_rw_n,  // write strobe
  input  wire logic                l_oe_n,  // read strobe
  input  wire logic [DPSEM_AW-1:0] l_addr,  // address
  input  wire logic [DPSEM_DW-1:0] l_d,     // write data
  output logic      [DPSEM_DW-1:0] l_q,     // read data
  input  wire logic                r_sel_n, // far token select
  input  wire logic                r_rw_n,  // far write strobe
  input  wire logic [2:0]          r_addr,  // far address
  input  wire logic                r_d,     // far write bit
  output logic      [7:0]          r_flag   // far flag view
);
  logic [7:0]          req_l, req_r;
  logic [7:0]          own_l = 8'h00;
  logic [7:0]          own_r = 8'h00;
  logic [DPSEM_DW-1:0] hold_l = 16'h0000;
  always @* begin
    if (!l_sel_n && l_ce_n && !l_rw_n) begin
      req_l[l_addr[2:0]] = l_d[0];
    end
  end
  always @* if (!r_sel_n && !r_rw_n) req_r[r_addr] = r_d;
  // flags gate nothing, only software reads them
  always @(req_l or req_r) begin
    for (int i = 0; i < 8; i++) begin
      if (req_l[i]) own_l[i] = 1'b0;
      if (req_r[i]) own_r[i] = 1'b0;
      // exact tie goes left: arbitrary but single
      if (!req_l[i] && !own_r[i]) own_l[i] = 1'b1;
      if (!req_r[i] && !own_l[i]) own_r[i] = 1'b1;
    end
  end
  always @(negedge (l_sel_n | l_oe_n)) begin
    hold_l = {16{~own_l[l_addr[2:0]]}};
  end
  // unselected bus shows inverse, never a stale value
  assign l_q = (!l_sel_n && !l_oe_n) ? hold_l : ~hold_l;
  assign r_flag = ~own_r;
endmodule // dpsem_dev_model

/* File: sim/dpsem_host_properties.sv */
`timescale 1ns/1ns
module dpsem_host_properties
  import dpsem_pkg::*;
(
  input wire logic                mclk,                 // clock
  input wire logic                reset_n,              // reset
  input wire logic                cmd_ready,            // idle
  input wire logic                done,                 // end pulse
  input wire logic                token_space_select_n, // token select
  input wire logic                chip_select_n,        // memory select
  input wire logic                rw_n,                 // write strobe
  input wire logic                output_enable_n,      // read strobe
  input wire logic [DPSEM_AW-1:0] addr,                 // address
  input wire logic [DPSEM_DW-1:0] data_out,             // write data
  input wire logic                data_oe               // data drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_mem_unselected:
    assert property (chip_select_n) else $error("memory select low");
  a_upper_addr_zero:
    assert property (!token_space_select_n |-> addr[15:3] == 13'h0000)
    else $error("upper address set");
  a_write_bit_only:
    assert property (!rw_n |-> data_oe && data_out[15:1] == 15'h0000)
    else $error("bad write data");
  a_setup_before_write:
    assert property ($fell(rw_n) |-> !$past(token_space_select_n, 2)
      && $stable(addr)) else $error("strobe without setup");
  a_strobe_width:
    assert property ($fell(rw_n) |-> !rw_n [*3] ##1 rw_n)
    else $error("strobe width wrong");
  a_read_write_apart:
    assert property (rw_n || output_enable_n) else $error("both strobes");
  a_strobe_selected:
    assert property (!rw_n || !output_enable_n |-> !token_space_select_n)
    else $error("strobe unselected");
  a_done_single:
    assert property (done |=> !done) else $error("done too long");
  a_idle_released:
    assert property (cmd_ready |-> token_space_select_n && !data_oe)
    else $error("idle but selected");
  c_write: cover property (!rw_n);
  c_read: cover property (!output_enable_n);
  c_done: cover property (done);
endmodule // dpsem_host_properties
bind dpsem_host dpsem_host_properties i_dpsem_host_properties (
  .mclk(mclk), .reset_n(reset_n), .cmd_ready(cmd_ready), .done(done),
  .token_space_select_n(token_space_select_n),
  .chip_select_n(chip_select_n), .rw_n(rw_n),
  .output_enable_n(output_enable_n), .addr(addr), .data_out(data_out),
  .data_oe(data_oe));

/* File: sim/tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end
module tb;
  import dpsem_pkg::*;
  logic mclk, reset_n, cmd_valid, cmd_acquire, cmd_ready, done, granted;
  logic init_busy;
  logic tsel_n, cs_n, rw_n, oe_n, data_oe, r_sel_n, r_rw_n, r_d;
  logic [2:0]  cmd_token, r_addr;
  logic [7:0]  r_flag;
  logic [15:0] addr, data_out, data_in;
  int          error_cnt = 0;
  int          n_compared = 0;
  dpsem_host i_dpsem_host (.mclk(mclk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_acquire(cmd_acquire), .cmd_token(cmd_token),
    .cmd_ready(cmd_ready), .done(done), .granted(granted),
    .init_busy(init_busy),
    .token_space_select_n(tsel_n), .chip_select_n(cs_n), .rw_n(rw_n),
    .output_enable_n(oe_n), .addr(addr), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in));
  dpsem_dev_model i_dpsem_dev_model (.l_sel_n(tsel_n), .l_ce_n(cs_n),
    .l_rw_n(rw_n), .l_oe_n(oe_n), .l_addr(addr), .l_d(data_out),
    .l_q(data_in), .r_sel_n(r_sel_n), .r_rw_n(r_rw_n), .r_addr(r_addr),
    .r_d(r_d), .r_flag(r_flag));
  task automatic cmd(input logic acq, input logic [2:0] tok);
    int n;
    n = 0;
    // present the command only once ready is seen, for one edge
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_acquire <= acq;
    cmd_token <= tok;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    do @(posedge mclk); while (done !== 1'b1 && ++n < 400);
    `CHK(n < 400, 1'b1)
  endtask
  task automatic rport(input logic [2:0] tok, input logic d);
    r_addr <= tok;
    r_d <= d;
    r_sel_n <= 1'b0;
    r_rw_n <= 1'b0;
    repeat (2) @(posedge mclk);
    r_sel_n <= 1'b1;
    r_rw_n <= 1'b1;
    @(posedge mclk);
  endtask
  task t_free;
    `CHK(init_busy, 1'b1)
    for (int i = 0; i < 8; i++) rport(3'(i), 1'b1);
    cmd(1'b0, 3'h7);
    `CHK(init_busy, 1'b0)
    `CHK(i_dpsem_dev_model.req_l, 8'hFF)
    cmd(1'b1, 3'h7);
    `CHK(granted, 1'b1)
    `CHK(r_flag[7], 1'b1)
    cmd(1'b0, 3'h7);
    `CHK(r_flag[7], 1'b1)
    $display("test free done");
  endtask
  task t_contend;
    rport(3'h2, 1'b0);
    cmd(1'b1, 3'h2);
    `CHK(granted, 1'b0)
    `CHK(i_dpsem_dev_model.req_l[2], 1'b0)
    rport(3'h2, 1'b1);
    cmd(1'b1, 3'h2);
    `CHK(granted, 1'b1)
    cmd(1'b0, 3'h2);
    `CHK(granted, 1'b0)
    $display("test contend done");
  endtask
  task t_sweep;
    for (int i = 0; i < 8; i++) begin
      cmd(1'b1, 3'(i));
      `CHK(i_dpsem_dev_model.own_l, 8'h01 << i)
      cmd(1'b0, 3'(i));
    end
    $display("test sweep done");
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run;
  end
  initial begin
    {reset_n, cmd_valid, cmd_acquire, cmd_token} = 6'h00;
    {r_sel_n, r_rw_n, r_addr, r_d} = 6'h3F;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_free;
    t_contend;
    t_sweep;
    complete_run;
  end
endmodule // tb
